// ---- hdl/smbus_slave_consts.svh ----
// Purpose: Constants for the serial management-bus slave port.
// Assumes: Included by bare name; definitions only.
// Notes: Function list below.
//
// Function
// - Answer to 7-bit address: fixed upper five bits 01011, two strap bits.
// - Strap grounded gives 00, tied high 01, unconnected 10.
// - Strap bits latched once after power-up; later changes ignored.
// - Strap sampled at first bus activity after power-up.
// - Start is data falling with clock high; then eight bits, address MSB first.
// - On address match, pull data low in the low period before ninth pulse.
// - On mismatch stay idle and release the bus until the transfer ends.
// - Direction bit 0 means master writes, 1 means master reads.
// - Each byte is nine clock pulses: eight data then receiver acknowledge.
// - Data changes only with clock low; data rising with clock high is stop.
// - Direction fixed by address byte; a change needs a new start.
// - Writes carry one or two bytes; reads return a single byte.
// - First byte after address in every write loads the register pointer.
// - A second write byte goes to the register the pointer selects.
// - Reads return the selected register without rewriting the pointer.
// - Send Byte, Receive Byte and Read Byte formats are supported.
`ifndef SMBUS_SLAVE_CONSTS_SVH
`define SMBUS_SLAVE_CONSTS_SVH
`define ADDR_PREFIX      5'h0b
`define STRAP_GND        2'h0
`define STRAP_VCC        2'h1
`define STRAP_OPEN       2'h2
`define BITS_PER_BYTE    4'h8
`define BIT_CNT_ZERO     4'h0
`define BIT_CNT_ONE      4'h1
`define BYTE_IDX_PTR     2'h0
`define BYTE_IDX_DATA    2'h1
`define BYTE_IDX_ONE     2'h1
`define BYTE_ZERO        8'h00
`define PTR_RESET        8'h00
`define DIR_READ         1'b1
`endif

// ---- hdl/smbus_slave_pkg.sv ----
// Purpose: Types for the serial management-bus slave port.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in smbus_slave_consts.svh.
package smbus_slave_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr_byte,
    st_wr_ack,
    st_rd_byte,
    st_rd_ack,
    st_ignore
  } slave_state_t;
endpackage

// ---- hdl/pin_events_if.sv ----
// Purpose: Synchronised pin levels and edge events passed to the slave core.
// Assumes: All signals are on clk.
// Notes: One-cycle pulses for edges.
`timescale 1ns/1ps
`default_nettype none
interface pin_events_if;
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic strap_hi;
  logic strap_lo;
  modport sync (output scl_lvl, scl_rise, scl_fall, sda_rise, sda_fall, strap_hi, strap_lo);
  modport core (input scl_lvl, scl_rise, scl_fall, sda_rise, sda_fall, strap_hi, strap_lo);
endinterface
`default_nettype wire

// ---- hdl/pin_event_sync.sv ----
// Purpose: Two-stage synchronisers for bus and strap pins; edge detection for the bus pins only.
// Assumes: Pins are asynchronous to clk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pin_event_sync
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Raw pins
  input  wire logic [3:0] pins_i,
  // Events
  pin_events_if.sync      ev
);
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;

  always_comb
  begin
    meta_next = ce ? pins_i : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
    prev_next = ce ? sync_reg[1:0] : prev_reg;
  end

  // Idle bus lines are high, so resetting to one avoids a false edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 4'h3;
      sync_reg <= 4'h3;
      prev_reg <= 2'h3;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign ev.scl_lvl  = sync_reg[0];
  assign ev.scl_rise = ce &  sync_reg[0] & ~prev_reg[0];
  assign ev.scl_fall = ce & ~sync_reg[0] &  prev_reg[0];
  assign ev.sda_rise = ce &  sync_reg[1] & ~prev_reg[1];
  assign ev.sda_fall = ce & ~sync_reg[1] &  prev_reg[1];
  assign ev.strap_hi = sync_reg[2];
  assign ev.strap_lo = sync_reg[3];
endmodule // pin_event_sync
`default_nettype wire

// ---- hdl/smbus_slave_register_access.sv ----
// Purpose: Management-bus slave: address decode, pointer, byte write and read.
// Assumes: Register contents live outside; reg_rdata is on clk.
// Notes: Bus pins are oversampled by clk, so SCL must be far slower than clk.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_consts.svh"
module smbus_slave_register_access
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Strap comparators on the shared strap pin
  input  wire logic       shared_strap_pin_near_vcc,
  input  wire logic       shared_strap_pin_near_gnd,
  // Register side
  output logic [7:0]      reg_ptr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  input  wire logic [7:0] reg_rdata,
  // Status
  output logic [1:0]      strap_addr_bits,
  output logic            strap_valid
);
  pin_events_if ev ();

  pin_event_sync u_sync
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .pins_i ({shared_strap_pin_near_gnd, shared_strap_pin_near_vcc, sda_i, scl_i}),
    .ev     (ev)
  );

  smbus_slave_pkg::slave_state_t state_reg;
  smbus_slave_pkg::slave_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [1:0] byte_idx_reg;
  logic [1:0] byte_idx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic       wr_reg;
  logic       wr_next;
  logic       oe_reg;
  logic       oe_next;
  logic [1:0] strap_reg;
  logic [1:0] strap_next;
  logic       strap_ok_reg;
  logic       strap_ok_next;
  logic [1:0] strap_decoded;
  logic       start_seen;
  logic       stop_seen;
  logic       activity;
  logic       addr_match;
  // Level copy of the synchronised data line, tracked from its edges.
  logic       sda_lvl_reg;
  logic       sda_lvl_next;

  // The strap is a three-level pin: both comparators quiet means open.
  always_comb
  begin
    if (ev.strap_lo)
      strap_decoded = `STRAP_GND;
    else if (ev.strap_hi)
      strap_decoded = `STRAP_VCC;
    else
      strap_decoded = `STRAP_OPEN;
  end

  assign start_seen = ev.sda_fall & ev.scl_lvl;
  assign stop_seen  = ev.sda_rise & ev.scl_lvl;
  assign activity   = ev.scl_fall | ev.sda_fall;
  // Before latching, the live strap is used so the first address still matches.
  assign addr_match = (shift_reg[7:1] == {`ADDR_PREFIX, strap_ok_reg ? strap_reg : strap_decoded});

  always_comb
  begin
    state_next    = state_reg;
    shift_next    = shift_reg;
    bit_cnt_next  = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    ptr_next      = ptr_reg;
    wdata_next    = wdata_reg;
    wr_next       = 1'b0;
    oe_next       = oe_reg;
    strap_next    = strap_reg;
    strap_ok_next = strap_ok_reg;
    if (ce)
    begin
      // Latched once; only a reset, standing in for power-up, rearms it.
      if (!strap_ok_reg && activity)
      begin
        strap_next    = strap_decoded;
        strap_ok_next = 1'b1;
      end
      if (start_seen)
      begin
        // A fresh start always reopens address phase, fixing the direction anew.
        state_next    = smbus_slave_pkg::st_addr;
        bit_cnt_next  = `BIT_CNT_ZERO;
        byte_idx_next = `BYTE_IDX_PTR;
        oe_next       = 1'b0;
      end
      else if (stop_seen)
      begin
        state_next = smbus_slave_pkg::st_idle;
        oe_next    = 1'b0;
      end
      else
      begin
        unique case (state_reg)
          smbus_slave_pkg::st_idle,
          smbus_slave_pkg::st_ignore:
          begin
            oe_next = 1'b0;
          end
          smbus_slave_pkg::st_addr,
          smbus_slave_pkg::st_wr_byte:
          begin
            if (ev.scl_rise)
            begin
              shift_next   = {shift_reg[6:0], ev.sda_rise | sda_lvl_reg};
              bit_cnt_next = bit_cnt_reg + `BIT_CNT_ONE;
            end
            else if (ev.scl_fall && bit_cnt_reg == `BITS_PER_BYTE)
            begin
              if (state_reg == smbus_slave_pkg::st_addr)
              begin
                if (addr_match)
                begin
                  state_next = smbus_slave_pkg::st_addr_ack;
                  oe_next    = 1'b1;
                end
                else
                begin
                  state_next = smbus_slave_pkg::st_ignore;
                end
              end
              else if (byte_idx_reg == `BYTE_IDX_PTR)
              begin
                ptr_next      = shift_reg;
                byte_idx_next = `BYTE_IDX_ONE;
                state_next    = smbus_slave_pkg::st_wr_ack;
                oe_next       = 1'b1;
              end
              else if (byte_idx_reg == `BYTE_IDX_DATA)
              begin
                wdata_next    = shift_reg;
                wr_next       = 1'b1;
                byte_idx_next = byte_idx_reg + `BYTE_IDX_ONE;
                state_next    = smbus_slave_pkg::st_wr_ack;
                oe_next       = 1'b1;
              end
              else
              begin
                // A third byte is refused: no acknowledge, bus released.
                state_next = smbus_slave_pkg::st_ignore;
              end
            end
          end
          smbus_slave_pkg::st_addr_ack:
          begin
            if (ev.scl_fall)
            begin
              bit_cnt_next = `BIT_CNT_ZERO;
              if (shift_reg[0] == `DIR_READ)
              begin
                shift_next = reg_rdata;
                state_next = smbus_slave_pkg::st_rd_byte;
                oe_next    = ~reg_rdata[7];
              end
              else
              begin
                state_next = smbus_slave_pkg::st_wr_byte;
                oe_next    = 1'b0;
              end
            end
          end
          smbus_slave_pkg::st_wr_ack:
          begin
            if (ev.scl_fall)
            begin
              state_next   = smbus_slave_pkg::st_wr_byte;
              bit_cnt_next = `BIT_CNT_ZERO;
              oe_next      = 1'b0;
            end
          end
          smbus_slave_pkg::st_rd_byte:
          begin
            if (ev.scl_rise)
            begin
              bit_cnt_next = bit_cnt_reg + `BIT_CNT_ONE;
            end
            else if (ev.scl_fall)
            begin
              if (bit_cnt_reg == `BITS_PER_BYTE)
              begin
                state_next = smbus_slave_pkg::st_rd_ack;
                oe_next    = 1'b0;
              end
              else
              begin
                shift_next = {shift_reg[6:0], 1'b0};
                oe_next    = ~shift_reg[6];
              end
            end
          end
          smbus_slave_pkg::st_rd_ack:
          begin
            // Only one byte is returned whatever the master answers.
            if (ev.scl_fall)
            begin
              state_next = smbus_slave_pkg::st_ignore;
            end
          end
        endcase
      end
    end
  end

  always_comb
  begin
    sda_lvl_next = sda_lvl_reg;
    if (ev.sda_rise)
      sda_lvl_next = 1'b1;
    else if (ev.sda_fall)
      sda_lvl_next = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= smbus_slave_pkg::st_idle;
      shift_reg    <= `BYTE_ZERO;
      bit_cnt_reg  <= `BIT_CNT_ZERO;
      byte_idx_reg <= `BYTE_IDX_PTR;
      ptr_reg      <= `PTR_RESET;
      wdata_reg    <= `BYTE_ZERO;
      wr_reg       <= 1'b0;
      oe_reg       <= 1'b0;
      strap_reg    <= `STRAP_OPEN;
      strap_ok_reg <= 1'b0;
      sda_lvl_reg  <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      bit_cnt_reg  <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      ptr_reg      <= ptr_next;
      wdata_reg    <= wdata_next;
      wr_reg       <= wr_next;
      oe_reg       <= oe_next;
      strap_reg    <= strap_next;
      strap_ok_reg <= strap_ok_next;
      sda_lvl_reg  <= sda_lvl_next;
    end
  end

  assign sda_o           = 1'b0;
  assign sda_oe          = oe_reg;
  assign reg_ptr         = ptr_reg;
  assign reg_wdata       = wdata_reg;
  assign reg_wr          = wr_reg;
  assign strap_addr_bits = strap_reg;
  assign strap_valid     = strap_ok_reg;
endmodule // smbus_slave_register_access
`default_nettype wire

// ---- verification/smbus_slave_properties.sv ----
// Purpose: Port-level checks for the management-bus slave port.
// Assumes: Bus clock far slower than clk.
// Notes: Bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_checker
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Bus and strap
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  input  wire logic       shared_strap_pin_near_vcc,
  input  wire logic       shared_strap_pin_near_gnd,
  // Register side and status
  input  wire logic [7:0] reg_ptr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [1:0] strap_addr_bits,
  input  wire logic       strap_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sda_o_low_a: assert property (sda_o == 1'b0)
    else $error("sda_o driven high");
  oe_moves_low_a: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("sda_oe moved with clock high");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr && $stable(reg_wdata))
    else $error("write strobe longer than one cycle");
  wr_keeps_ptr_a: assert property (reg_wr |-> $stable(reg_ptr))
    else $error("data byte changed pointer");
  ptr_moves_low_a: assert property ($changed(reg_ptr) |-> !scl_i)
    else $error("pointer moved with clock high");
  wr_while_low_a: assert property (reg_wr |-> !scl_i)
    else $error("write strobe with clock high");
  strap_hold_a: assert property (strap_valid |=> strap_valid && $stable(strap_addr_bits))
    else $error("strap bits changed after latch");
  strap_code_a: assert property (strap_addr_bits != 2'h3)
    else $error("illegal strap code");
  cover property (reg_wr);
  cover property ($rose(strap_valid));
  cover property ($rose(sda_oe));
endmodule // smbus_slave_checker
bind smbus_slave_register_access smbus_slave_checker u_chk
(
  .clk, .rst_n, .ce, .scl_i, .sda_i, .sda_o, .sda_oe,
  .shared_strap_pin_near_vcc, .shared_strap_pin_near_gnd,
  .reg_ptr, .reg_wdata, .reg_wr, .reg_rdata, .strap_addr_bits, .strap_valid
);
`default_nettype wire

// ---- verification/smbus_master_model.sv ----
// Purpose: Behavioural bus master driving clock and open-drain data.
// Assumes: 160 ns bus clock period, quarter period of 5 clk.
// Notes: Clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model
(
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_cond();
    sda_low = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(5);
  endtask
  // Data only moves with the clock low, so no false start or stop appears.
  task automatic put_bit(input logic b, output logic got);
    sda_low = ~b;
    tick(5);
    scl = 1'b1;
    tick(5);
    got = sda;
    tick(5);
    scl = 1'b0;
    tick(5);
  endtask
  // Eight bits then the acknowledge slot; sending all ones releases the line.
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--)
      put_bit(tx[i], rx[i]);
    put_bit(~ack_out, ack_in);
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(5);
    sda_low = 1'b0;
    tick(10);
  endtask
endmodule // smbus_master_model
`default_nettype wire

// ---- verification/smbus_slave_register_access_bench.sv ----
// Purpose: Self-checking bench for the management-bus slave port.
// Assumes: Register contents modelled as pointer xor 5a.
// Notes: Each power-up is a fresh reset.
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_register_access_bench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       near_vcc = 1'b0;
  logic       near_gnd = 1'b0;
  logic       ce_en = 1'b1;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe;
  logic       reg_wr;
  logic       strap_valid;
  logic [7:0] reg_ptr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] wr_data;
  logic [1:0] strap_addr_bits;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         wr_count = 0;
  int         oe_seen = 0;
  wire logic  sda;
  // Pull-up on data: low whenever either side pulls.
  assign sda = ~(sda_low | sda_oe);
  assign reg_rdata = reg_ptr ^ 8'h5a;
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    if (sda_oe === 1'b1) oe_seen++;
    if (reg_wr === 1'b1)
    begin
      wr_count++;
      wr_data = reg_wdata;
    end
  end
  smbus_master_model m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  smbus_slave_register_access dut (
    .clk(clk), .rst_n(rst_n), .ce(ce_en), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .shared_strap_pin_near_vcc(near_vcc),
    .shared_strap_pin_near_gnd(near_gnd), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .strap_addr_bits(strap_addr_bits),
    .strap_valid(strap_valid));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic power_up(input logic [1:0] code);
    rst_n = 1'b0;
    near_gnd = (code == 2'h0);
    near_vcc = (code == 2'h1);
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    m.tick(5);
  endtask
  // One transfer: address, n bytes, stop. Reads clock n bytes, each followed by no-acknowledge.
  task automatic txn(input logic [6:0] a, input logic rd, input int n,
                     input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2,
                     output logic ack, output logic [7:0] rx, output logic last);
    logic       a_in;
    logic       k;
    logic [7:0] r;
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    k = 1'b1;
    m.start_cond();
    m.xfer({a, rd}, 1'b0, r, a_in);
    ack = ~a_in;
    for (int i = 0; i < n; i++)
      m.xfer(rd ? 8'hff : d[i], 1'b0, rx, k);
    last = ~k;
    m.stop_cond();
  endtask
  task automatic strap_codes();
    logic       ack;
    logic       last;
    logic [7:0] rx;
    for (int c = 0; c < 3; c++)
    begin
      power_up(c[1:0]);
      check({7'h0, strap_valid}, 8'h00);
      txn({5'h0b, c[1:0]}, 1'b0, 1, 8'h10 + c[7:0], 8'h0, 8'h0, ack, rx, last);
      check({7'h0, ack}, 8'h01);
      check({6'h0, strap_addr_bits}, c[7:0]);
      check(reg_ptr, 8'h10 + c[7:0]);
    end
    near_gnd = 1'b1;
    txn(7'h2e, 1'b0, 1, 8'h20, 8'h0, 8'h0, ack, rx, last);
    check({7'h0, ack}, 8'h01);
    check({6'h0, strap_addr_bits}, 8'h02);
  endtask
  task automatic mismatch();
    logic       ack;
    logic       last;
    logic [7:0] rx;
    oe_seen = 0;
    txn(7'h2f, 1'b0, 2, 8'h77, 8'h66, 8'h0, ack, rx, last);
    txn(7'h0e, 1'b1, 1, 8'h0, 8'h0, 8'h0, ack, rx, last);
    check(oe_seen[7:0], 8'h00);
    check(reg_ptr, 8'h20);
    check(rx, 8'hff);
    // With the enable low the port is frozen: no answer and no pointer load.
    ce_en = 1'b0;
    txn(7'h2e, 1'b0, 1, 8'h55, 8'h0, 8'h0, ack, rx, last);
    ce_en = 1'b1;
    m.tick(5);
    check({7'h0, ack}, 8'h00);
    check(reg_ptr, 8'h20);
    check(oe_seen[7:0], 8'h00);
  endtask
  task automatic write_pair();
    logic       ack;
    logic       last;
    logic [7:0] rx;
    wr_count = 0;
    txn(7'h2e, 1'b0, 2, 8'h33, 8'ha5, 8'h0, ack, rx, last);
    check({7'h0, last}, 8'h01);
    check(reg_ptr, 8'h33);
    check(wr_data, 8'ha5);
    txn(7'h2e, 1'b0, 3, 8'h44, 8'h01, 8'h02, ack, rx, last);
    check({7'h0, last}, 8'h00);
    check(wr_data, 8'h01);
    check(wr_count[7:0], 8'h02);
  endtask
  task automatic read_back();
    logic       ack;
    logic       last;
    logic [7:0] rx;
    wr_count = 0;
    txn(7'h2e, 1'b0, 1, 8'h3c, 8'h0, 8'h0, ack, rx, last);
    check(wr_count[7:0], 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      txn(7'h2e, 1'b1, 1, 8'h0, 8'h0, 8'h0, ack, rx, last);
      check({7'h0, ack}, 8'h01);
      check(rx, 8'h66);
    end
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    strap_codes();
    mismatch();
    write_pair();
    read_back();
    tally_and_finish();
  end
endmodule // smbus_slave_register_access_bench
`default_nettype wire
